// File: design/special_register_move_decoder.sv
// execute stage for indirect segment read, masked cond load, status bits
`timescale 1ns/1ps
`include "srmove_regs.svh"

// Overview of operation
// - gpr bits 0-3 select segment, written to destination
// - segment read is privileged, faults in user mode
// - record form leaves field 0, never touches xer
// - cond load: opcode 144, source, eight-bit mask
// - each set mask bit replaces its nibble
// - several mask bits all update correctly
// - status-bit clear forces indexed bit to 0
// - status-bit set forces indexed bit to 1
// - record flag copies four summary bits to field 1
// - status-bit moves never modify xer
// - status bits 1 and 2 are not writable
module special_register_move_decoder (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst,
    // issue side
    input  wire logic                 insn_valid,
    input  wire srmove_pkg::word_t    insn,
    input  wire logic                 user_mode,
    // general register read data, indexed by the fields shown below
    input  wire srmove_pkg::word_t    gpr_rdata_a,
    input  wire srmove_pkg::word_t    gpr_rdata_b,
    // segment register load port
    input  wire logic                 seg_we,
    input  wire srmove_pkg::seg_idx_t seg_widx,
    input  wire srmove_pkg::word_t    seg_wdata,
    // general register read indices (combinational, for the file)
    output srmove_pkg::reg_idx_t      source_gpr_index,
    output srmove_pkg::reg_idx_t      index_source_gpr,
    // general register write back
    output logic                      gpr_we,
    output srmove_pkg::reg_idx_t      dest_gpr_index,
    output srmove_pkg::word_t         gpr_wdata,
    // architectural state
    output srmove_pkg::word_t         condition_reg,
    output srmove_pkg::word_t         fp_status_control_reg,
    // outcome flags
    output logic                      priv_fault,
    output logic                      pass_on,
    output logic                      pass_insn_valid,
    output srmove_pkg::word_t         pass_insn,
    output logic                      xer_we
);
    import srmove_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        word_t [15:0] seg;
        word_t        cond;
        word_t        fps;
        logic         gpr_we;
        reg_idx_t     dest;
        word_t        gpr_wdata;
        logic         fault;
        logic         pass;
        word_t        pass_insn;
    } state_t;

    state_t s_q;
    state_t s_d;

    op_kind_t   op_kind;
    reg_idx_t   field_a;
    reg_idx_t   field_b;
    logic [7:0] cond_field_mask;
    logic       record_flag;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    insn_field_decode u_decode (
        .insn            (insn),
        .user_mode       (user_mode),
        .op_kind         (op_kind),
        .field_a         (field_a),
        .field_b         (field_b),
        .cond_field_mask (cond_field_mask),
        .record_flag     (record_flag)
    );

    // the register file answers in the same cycle these are shown
    assign source_gpr_index = field_a;
    assign index_source_gpr = field_b;

    // big-endian bit index to little-endian vector position
    function automatic logic [4:0] be_pos(input logic [4:0] idx);
        be_pos = 5'd31 - idx;
    endfunction

    // nibble merge under mask; mask bit 0 (insn bit 12) owns bits 0-3
    function automatic word_t mask_merge(input word_t old_v,
                                         input word_t new_v,
                                         input logic [7:0] m);
        word_t r;
        r = old_v;
        for (int k = 0; k < 8; k++) begin
            if (m[k]) begin
                r[k*4 +: 4] = new_v[k*4 +: 4];
            end
        end
        mask_merge = r;
    endfunction

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic [4:0] pos;
        word_t      fps_n;
        pos   = be_pos(field_a);
        fps_n = s_q.fps;
        s_d   = s_q;
        s_d.gpr_we    = 1'b0;
        s_d.fault     = 1'b0;
        s_d.pass      = 1'b0;
        s_d.dest      = field_a;
        s_d.gpr_wdata = s_q.gpr_wdata;
        s_d.pass_insn = insn;

        // segment loads from the mmu side
        if (seg_we) begin
            s_d.seg[seg_widx] = seg_wdata;
        end

        if (insn_valid) begin
            case (op_kind)
                op_seg_read: begin
                    // field 0 left as is; undefined allows no update
                    s_d.gpr_we    = 1'b1;
                    s_d.gpr_wdata = s_q.seg[gpr_rdata_b[31:28]];
                end
                op_priv_fault: begin
                    s_d.fault = 1'b1;
                end
                op_cond_load: begin
                    // every selected field updates, not just one
                    s_d.cond = mask_merge(s_q.cond, gpr_rdata_a,
                                          cond_field_mask);
                end
                op_fps_clear, op_fps_set: begin
                    // summary bits 1 and 2 are derived, writes drop
                    if (field_a != `FPS_BIT_FEX &&
                        field_a != `FPS_BIT_VX) begin
                        fps_n[pos] = (op_kind == op_fps_set);
                    end
                    s_d.fps = fps_n;
                    // record form copies fx fex vx ox to field 1
                    if (record_flag) begin
                        s_d.cond[27:24] = fps_n[31:28];
                    end
                end
                op_none: begin
                    s_d.pass = 1'b1;
                end
                default: begin
                    s_d.pass = 1'b1;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            s_q.seg       <= {16{`SEG_RESET}};
            s_q.cond      <= `COND_RESET;
            s_q.fps       <= `FPS_RESET;
            s_q.gpr_we    <= 1'b0;
            s_q.dest      <= 5'h00;
            s_q.gpr_wdata <= 32'h0000_0000;
            s_q.fault     <= 1'b0;
            s_q.pass      <= 1'b0;
            s_q.pass_insn <= 32'h0000_0000;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign gpr_we                = s_q.gpr_we;
    assign dest_gpr_index        = s_q.dest;
    assign gpr_wdata             = s_q.gpr_wdata;
    assign condition_reg         = s_q.cond;
    assign fp_status_control_reg = s_q.fps;
    assign priv_fault            = s_q.fault;
    assign pass_on               = s_q.pass;
    assign pass_insn_valid       = s_q.pass;
    assign pass_insn             = s_q.pass_insn;
    // none of these instructions writes the fixed-point exception reg
    assign xer_we                = 1'b0;

endmodule

// File: inc/srmove_regs.svh
// constants for the special register move decoder: fields, opcodes, bits
`ifndef SRMOVE_REGS_SVH
`define SRMOVE_REGS_SVH

// primary and extended opcodes
`define OP_PRIM_31        6'd31
`define OP_PRIM_63        6'd63
`define XO_SEG_INDIRECT   10'd659
`define XO_COND_LOAD      10'd144
`define XO_FPS_CLEAR      10'd70
`define XO_FPS_SET        10'd38

// status register bit positions (big-endian numbering, bit 0 = msb)
`define FPS_BIT_FX        5'd0
`define FPS_BIT_FEX       5'd1
`define FPS_BIT_VX        5'd2
`define FPS_BIT_OX        5'd3

// reset values of the architectural registers held here
`define COND_RESET        32'h0000_0000
`define FPS_RESET         32'h0000_0000
`define SEG_RESET         32'h0000_0000

// condition field used by the record form of the status-bit moves
`define COND_FIELD_REC    3'd1

`endif

// File: inc/srmove_pkg.sv
// types shared by the special register move decoder
package srmove_pkg;

    typedef logic [31:0] word_t;
    typedef logic [4:0]  reg_idx_t;
    typedef logic [3:0]  seg_idx_t;

    typedef enum logic [2:0] {
        op_none,
        op_seg_read,
        op_cond_load,
        op_fps_clear,
        op_fps_set,
        op_priv_fault
    } op_kind_t;

endpackage

// File: design/insn_field_decode.sv
// decodes one instruction word into its operation and fields
`timescale 1ns/1ps
`include "srmove_regs.svh"

module insn_field_decode
    import srmove_pkg::*;
(
    // instruction word and privilege state
    input  wire srmove_pkg::word_t    insn,
    input  wire logic                 user_mode,
    // decoded result
    output srmove_pkg::op_kind_t      op_kind,
    output srmove_pkg::reg_idx_t      field_a,
    output srmove_pkg::reg_idx_t      field_b,
    output logic [7:0]                cond_field_mask,
    output logic                      record_flag
);

    // bit 0 of the architecture is the msb of the word
    function automatic logic [9:0] ext_opcode(input word_t w);
        ext_opcode = w[10:1];
    endfunction

    logic [5:0] prim;
    logic [9:0] xo;

    // field slicing
    always_comb begin
        prim            = insn[31:26];
        xo              = ext_opcode(insn);
        field_a         = insn[25:21];
        field_b         = insn[15:11];
        cond_field_mask = insn[19:12];
        record_flag     = insn[0];
    end

    // opcode match; anything else falls through untouched
    always_comb begin
        op_kind = op_none;
        if (prim == `OP_PRIM_31 && xo == `XO_SEG_INDIRECT) begin
            op_kind = user_mode ? op_priv_fault : op_seg_read;
        end else if (prim == `OP_PRIM_31 && xo == `XO_COND_LOAD) begin
            op_kind = op_cond_load;
        end else if (prim == `OP_PRIM_63 && xo == `XO_FPS_CLEAR) begin
            op_kind = op_fps_clear;
        end else if (prim == `OP_PRIM_63 && xo == `XO_FPS_SET) begin
            op_kind = op_fps_set;
        end
    end

endmodule

// File: tb/gpr_file_model.sv
// general register file model standing behind the decoder's read ports
`timescale 1ns/1ps
module gpr_file_model
    import srmove_pkg::*;
(
    // clock
    input  wire logic                 clk,
    // read and write ports
    input  wire srmove_pkg::reg_idx_t rd_idx_a,
    input  wire srmove_pkg::reg_idx_t rd_idx_b,
    input  wire logic                 wr_en,
    input  wire srmove_pkg::reg_idx_t wr_idx,
    input  wire srmove_pkg::word_t    wr_data,
    output srmove_pkg::word_t         rd_data_a,
    output srmove_pkg::word_t         rd_data_b
);
    word_t regs [32];
    // same-cycle reads; unset entries stay unknown, so stray use shows
    assign rd_data_a = regs[rd_idx_a];
    assign rd_data_b = regs[rd_idx_b];
    // write back from the decoder
    always @(posedge clk) if (wr_en) regs[wr_idx] <= wr_data;
endmodule

// File: tb/srmove_chk.sv
// concurrent checks on the special register move decoder ports
`timescale 1ns/1ps
`include "srmove_regs.svh"
module srmove_chk
    import srmove_pkg::*;
(
    // clock, reset and issue
    input wire logic                 clk,
    input wire logic                 rst,
    input wire logic                 insn_valid,
    input wire srmove_pkg::word_t    insn,
    input wire logic                 user_mode,
    input wire srmove_pkg::word_t    gpr_rdata_a,
    // results
    input wire logic                 gpr_we,
    input wire srmove_pkg::reg_idx_t dest_gpr_index,
    input wire srmove_pkg::word_t    condition_reg,
    input wire srmove_pkg::word_t    fp_status_control_reg,
    input wire logic                 priv_fault,
    input wire logic                 pass_on,
    input wire srmove_pkg::word_t    pass_insn,
    input wire logic                 xer_we
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    // opcode classes of the word being taken
    wire p31 = insn_valid && insn[31:26] == `OP_PRIM_31;
    wire p63 = insn_valid && insn[31:26] == `OP_PRIM_63;
    wire seg_rd = p31 && insn[10:1] == `XO_SEG_INDIRECT;
    wire cr_ld = p31 && insn[10:1] == `XO_COND_LOAD;
    wire b_clr = p63 && insn[10:1] == `XO_FPS_CLEAR;
    wire b_set = p63 && insn[10:1] == `XO_FPS_SET;
    wire b_ok = insn[25:21] != 5'h1 && insn[25:21] != 5'h2;
    wire odd = insn_valid && !(seg_rd || cr_ld || b_clr || b_set);
    logic [31:0] cmask;
    // mask bit at insn[12+k] selects nibble k of the condition word
    for (genvar k = 0; k < 8; k++) begin : g_m
        assign cmask[4*k+:4] = {4{insn[12+k]}};
    end
    a_xer_untouched: assert property (!xer_we)
        else $error("fixed-point exception write seen");
    a_seg_priv_fault: assert property (
        seg_rd && user_mode |=> priv_fault && !gpr_we)
        else $error("segment read in user mode not refused");
    a_seg_write_dest: assert property (
        seg_rd && !user_mode |=> gpr_we && !priv_fault
        && dest_gpr_index == $past(insn[25:21]))
        else $error("segment read write back wrong");
    a_cond_mask_load: assert property (
        cr_ld |=> condition_reg == (($past(condition_reg) & ~$past(cmask))
        | ($past(gpr_rdata_a) & $past(cmask))))
        else $error("masked condition load wrong");
    a_bit_clear_to0: assert property (
        b_clr && b_ok |=> !fp_status_control_reg[31 - $past(insn[25:21])])
        else $error("status bit not cleared");
    a_bit_set_to1: assert property (
        b_set && b_ok |=> fp_status_control_reg[31 - $past(insn[25:21])])
        else $error("status bit not set");
    a_summary_bits_fixed: assert property (
        b_clr || b_set |=> $stable(fp_status_control_reg[30:29]))
        else $error("derived status bits changed");
    a_record_copy: assert property (
        (b_clr || b_set) && insn[0] |=>
        condition_reg[27:24] == fp_status_control_reg[31:28])
        else $error("record copy to field 1 wrong");
    a_norec_field1: assert property (
        (b_clr || b_set) && !insn[0] |=> $stable(condition_reg))
        else $error("condition changed without record flag");
    a_pass_unmatched: assert property (
        odd |=> pass_on && !gpr_we && pass_insn == $past(insn)
        && $stable(condition_reg) && $stable(fp_status_control_reg))
        else $error("unmatched word not handed on cleanly");
    c_fault: cover property (seg_rd && user_mode ##1 priv_fault);
    c_multi: cover property (cr_ld && $countones(insn[19:12]) > 1);
    c_rec: cover property (b_set && insn[0]);
endmodule
bind special_register_move_decoder srmove_chk srmove_chk_inst (
    .clk(clk), .rst(rst), .insn_valid(insn_valid), .insn(insn),
    .user_mode(user_mode), .gpr_rdata_a(gpr_rdata_a), .gpr_we(gpr_we),
    .dest_gpr_index(dest_gpr_index), .condition_reg(condition_reg),
    .fp_status_control_reg(fp_status_control_reg),
    .priv_fault(priv_fault), .pass_on(pass_on), .pass_insn(pass_insn),
    .xer_we(xer_we));

// File: tb/special_register_move_decoder_test.sv
// self-checking bench for the special register move decoder
`timescale 1ns/1ps
`include "srmove_regs.svh"
`define CHK(n, e, s) begin n_checks++; if ((s) !== (e)) begin \
    fail_count++; $display("[ERR] %s exp %h got %h", n, e, s); end end
module special_register_move_decoder_test;
    import srmove_pkg::*;
    logic clk = 0, rst = 1, insn_valid = 0, user_mode = 0, seg_we = 0;
    logic gpr_we, fault, pass_on, xer_we, pv;
    word_t insn = '0, seg_wdata = '0, rd_a, rd_b, wdata, cr, fps, pass_w;
    word_t seg_e [16], odd [3], cr_e, fps_e, m;
    seg_idx_t seg_widx = '0;
    reg_idx_t ia, ib, dest;
    logic [7:0] masks [5] = '{8'h80, 8'h01, 8'ha5, 8'hff, 8'h3c};
    int fail_count = 0, n_checks = 0, cyc = 0;
    special_register_move_decoder special_register_move_decoder_inst (
        .clk(clk), .rst(rst), .insn_valid(insn_valid), .insn(insn),
        .user_mode(user_mode), .gpr_rdata_a(rd_a), .gpr_rdata_b(rd_b),
        .seg_we(seg_we), .seg_widx(seg_widx), .seg_wdata(seg_wdata),
        .source_gpr_index(ia), .index_source_gpr(ib), .gpr_we(gpr_we),
        .dest_gpr_index(dest), .gpr_wdata(wdata), .condition_reg(cr),
        .fp_status_control_reg(fps), .priv_fault(fault), .pass_on(pass_on),
        .pass_insn_valid(pv), .pass_insn(pass_w), .xer_we(xer_we));
    gpr_file_model gpr_file_model_inst (
        .clk(clk), .rd_idx_a(ia), .rd_idx_b(ib), .wr_en(gpr_we),
        .wr_idx(dest), .wr_data(wdata), .rd_data_a(rd_a), .rd_data_b(rd_b));
    always #10 clk = ~clk;
    // hang guard: the whole sequence needs about 200 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            fail_count++;
            close_out();
        end
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic do_reset();
        @(posedge clk) #1 rst = 1;
        repeat (3) @(posedge clk);
        #1 rst = 0;
    endtask
    // one word for one cycle; on return its results have landed
    task automatic issue(word_t w, logic u);
        @(posedge clk) #1;
        insn = w;
        user_mode = u;
        insn_valid = 1;
        @(posedge clk) #1 insn_valid = 0;
    endtask
    function automatic word_t xw(logic [5:0] po, logic [4:0] a,
                                 logic [4:0] b, logic [9:0] xo, logic rc);
        return {po, a, 5'h0, b, xo, rc};
    endfunction
    initial begin
        do_reset();
        `CHK("cond reset", 32'h0, cr)
        `CHK("fps reset", 32'h0, fps)
        for (int i = 0; i < 16; i++) begin
            seg_e[i] = 32'h1357_0000 ^ (i * 32'h0101_1111);
            @(posedge clk) #1;
            seg_we = 1;
            seg_widx = 4'(i);
            seg_wdata = seg_e[i];
        end
        @(posedge clk) #1 seg_we = 0;
        // index held in the top nibble; odd i uses the record form
        for (int i = 0; i < 16; i++) begin
            gpr_file_model_inst.regs[3] = {4'(i), 28'h0abcdef};
            issue(xw(`OP_PRIM_31, 5'(i + 4), 5'h3, `XO_SEG_INDIRECT, i[0]), 0);
            `CHK("seg we", 1'b1, gpr_we)
            `CHK("seg dest", 5'(i + 4), dest)
            `CHK("seg data", seg_e[i], wdata)
            `CHK("seg cond", 32'h0, cr)
            `CHK("seg xer", 1'b0, xer_we)
        end
        issue(xw(`OP_PRIM_31, 5'h9, 5'h3, `XO_SEG_INDIRECT, 1'b0), 1);
        `CHK("fault", 1'b1, fault)
        `CHK("fault we", 1'b0, gpr_we)
        cr_e = 0;
        foreach (masks[j]) begin
            gpr_file_model_inst.regs[6] = 32'h7542_ffee ^ (j * 32'h1111_1111);
            m = 0;
            for (int k = 0; k < 8; k++) if (masks[j][k]) m[4*k+:4] = 4'hf;
            cr_e = (cr_e & ~m) | (gpr_file_model_inst.regs[6] & m);
            issue(xw(`OP_PRIM_31, 5'h6, 5'h0, `XO_COND_LOAD, 1'b0)
                  | (32'(masks[j]) << 12), 0);
            `CHK("cond load", cr_e, cr)
        end
        // set every bit, then clear every bit; odd indices record
        fps_e = 0;
        for (int op = 0; op < 2; op++) begin
            for (int b = 0; b < 32; b++) begin
                if (b != 1 && b != 2) fps_e[31 - b] = (op == 0);
                if (b[0]) cr_e[27:24] = fps_e[31:28];
                issue(xw(`OP_PRIM_63, 5'(b), 5'h0,
                         op ? `XO_FPS_CLEAR : `XO_FPS_SET, b[0]), 0);
                `CHK("fps", fps_e, fps)
                `CHK("rec cond", cr_e, cr)
                `CHK("fps xer", 1'b0, xer_we)
            end
        end
        odd = '{xw(`OP_PRIM_31, 5'h1, 5'h2, 10'h153, 1'b0),
                xw(`OP_PRIM_63, 5'h1, 5'h2, `XO_SEG_INDIRECT, 1'b1),
                xw(`OP_PRIM_31, 5'h3, 5'h0, `XO_FPS_CLEAR, 1'b0)};
        foreach (odd[j]) begin
            issue(odd[j], 0);
            `CHK("pass", 1'b1, pass_on)
            `CHK("pass valid", 1'b1, pv)
            `CHK("pass word", odd[j], pass_w)
            `CHK("pass cond", cr_e, cr)
            `CHK("pass fps", fps_e, fps)
        end
        do_reset();
        `CHK("cond rst", 32'h0, cr)
        `CHK("fps rst", 32'h0, fps)
        close_out();
    end
endmodule
